// ==== bsf_pkg.sv ====
// Functional notes
// - Over-temperature sets at or above its limit, clears below limit minus hysteresis; defaults 550 and 50 tenths of a degree.
// - Under-temperature sets at or below its limit (default 0), clears above limit plus hysteresis.
// - Charge alarm sets when charge reaches alarm-set percent (99), clears below alarm-clear percent (95).
// - Alarm-set percent of -1 makes the charge alarm set on primary charge termination instead.
// - Full charge sets when charge reaches full-set percent, clears below full-clear percent (98).
// - Full-set percent of -1, its default, makes full charge set on primary charge termination.
// - A temperature change of at least the delta setting (50) since the last run retriggers gauging.
// - Standby current starts at the initial setting (-3 mA) and updates each second while |I| > deadband (5) and I <= twice the setting.
// - Discharge current is negative and all current comparisons are signed.
// - Max load starts at the initial setting (-200 mA) and takes the present current when it compares greater than the setting.
// - After discharge below 50% and a charge to full, max load becomes the mean of itself and the setting.
// - First charge warning sets at or below its set level (10), clears at or above its clear level (15).
// - Final discharge warning sets at or below its set level (2), clears at or above its clear level (5).
package bsf_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_FLAGS = 8'h00;
  localparam logic [7:0] REG_INT_STATUS = 8'h04;
  localparam logic [7:0] REG_INT_MASK = 8'h08;
  localparam logic [7:0] REG_TEMP_LIMITS = 8'h0C;
  localparam logic [7:0] REG_TEMP_HYS = 8'h10;
  localparam logic [7:0] REG_CHARGE_PCT = 8'h14;
  localparam logic [7:0] REG_SOC_WARN = 8'h18;
  localparam logic [7:0] REG_CURRENT_CFG = 8'h1C;
  localparam logic [7:0] REG_STANDBY = 8'h20;
  localparam logic [7:0] REG_MAX_LOAD = 8'h24;

  localparam logic [31:0] TEMP_LIMITS_RST = 32'h0000_0226;
  localparam logic [31:0] TEMP_HYS_RST = 32'h0032_0032;
  localparam logic [31:0] CHARGE_PCT_RST = 32'h62FF_5F63;
  localparam logic [31:0] SOC_WARN_RST = 32'h0502_0F0A;
  localparam logic [31:0] CURRENT_CFG_RST = 32'hFF38_05FD;
  localparam logic [6:0] INT_MASK_RST = 7'h00;

  // Field positions: byte fields at 0/8/16/24, half words at 0/16
  localparam int LSB_B0 = 0;
  localparam int LSB_B1 = 8;
  localparam int LSB_B2 = 16;
  localparam int LSB_B3 = 24;
  localparam int LSB_H0 = 0;
  localparam int LSB_H1 = 16;

  localparam logic [7:0] PCT_TERM_SEL = 8'hFF;
  localparam logic [7:0] SOC_HALF = 8'h32;
  localparam int SIM_BIT = 6;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam longint CLK_KHZ = 125000;
  localparam longint STANDBY_PERIOD_MS = 1000;
  localparam int unsigned STANDBY_PERIOD_CYC =
    int'(STANDBY_PERIOD_MS * CLK_KHZ);

  typedef struct packed {
    logic finalSoc;
    logic firstSoc;
    logic fullCharge;
    logic chargeAlarm;
    logic underTemp;
    logic overTemp;
  } bsf_flags_t;
endpackage

// ==== bsf_hyst_flag.sv ====
`timescale 1ns/100ps
`default_nettype none
module bsf_hyst_flag (
  input wire logic clock,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic tick,
  input wire logic setCond,
  input wire logic clrCond,
  output logic flag,
  output logic rise
);
  // Set takes priority if the levels are programmed to overlap
  always_ff @(posedge clock) begin
    if (srst) begin
      flag <= 1'b0;
    end else if (clkEn && tick) begin
      if (setCond) begin
        flag <= 1'b1;
      end else if (clrCond) begin
        flag <= 1'b0;
      end
    end
  end

  assign rise = clkEn && tick && setCond && !flag;

  property p_holdBetween;
    @(posedge clock) disable iff (srst)
      clkEn && tick && !setCond && !clrCond |=> $stable(flag);
  endproperty
  a_holdBetween: assert property (p_holdBetween)
    else $error("flag moved between levels");

  property p_clearDrop;
    @(posedge clock) disable iff (srst)
      clkEn && tick && !setCond && clrCond |=> !flag;
  endproperty
  a_clearDrop: assert property (p_clearDrop)
    else $error("flag not cleared");
endmodule // bsf_hyst_flag
`default_nettype wire

// ==== bsf_period_tick.sv ====
`timescale 1ns/100ps
`default_nettype none
module bsf_period_tick #(
  parameter int unsigned CYCLES = 1000
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic clkEn,
  output logic pulse
);
  logic [31:0] cnt_r;

  assign pulse = clkEn && (cnt_r == 32'(CYCLES - 1));

  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_r <= '0;
    end else if (clkEn) begin
      cnt_r <= pulse ? '0 : cnt_r + 32'h0000_0001;
    end
  end

  property p_wrap;
    @(posedge clock) disable iff (srst) pulse |=> cnt_r == '0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("period counter did not wrap");
endmodule // bsf_period_tick
`default_nettype wire

// ==== bsf_flag_thresholds.sv ====
`timescale 1ns/100ps
`default_nettype none
module bsf_flag_thresholds #(
  parameter int unsigned STANDBY_PERIOD_CYC = bsf_pkg::STANDBY_PERIOD_CYC
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic updateTick,
  input wire logic signed [15:0] temperature,
  input wire logic signed [15:0] current,
  input wire logic [7:0] chargePercent,
  input wire logic primaryTermination,
  output bsf_pkg::bsf_flags_t flags,
  output logic signed [15:0] standby_current_value,
  output logic signed [15:0] max_load_current_value,
  output logic simUpdate,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic awHeld_r, wHeld_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic doWrite, mapped;
  logic [31:0] tempLimits_r, tempHys_r, chargePct_r, socWarn_r;
  logic [31:0] currentCfg_r, rdMux;
  logic [6:0] intStatus_r, intMask_r, events;
  logic rdMapped;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
  assign mapped = awAddr_r inside {bsf_pkg::REG_INT_STATUS,
    bsf_pkg::REG_INT_MASK, bsf_pkg::REG_TEMP_LIMITS,
    bsf_pkg::REG_TEMP_HYS, bsf_pkg::REG_CHARGE_PCT,
    bsf_pkg::REG_SOC_WARN, bsf_pkg::REG_CURRENT_CFG};

  always_ff @(posedge clock) begin
    if (srst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= '0;
      wStrb_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= bsf_pkg::RESP_OKAY;
    end else if (clkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped ? bsf_pkg::RESP_OKAY : bsf_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic wrHit(input logic [7:0] a);
    return doWrite && awAddr_r == a;
  endfunction

  always_ff @(posedge clock) begin
    if (srst) begin
      tempLimits_r <= bsf_pkg::TEMP_LIMITS_RST;
      tempHys_r <= bsf_pkg::TEMP_HYS_RST;
      chargePct_r <= bsf_pkg::CHARGE_PCT_RST;
      socWarn_r <= bsf_pkg::SOC_WARN_RST;
      currentCfg_r <= bsf_pkg::CURRENT_CFG_RST;
      intMask_r <= bsf_pkg::INT_MASK_RST;
    end else if (clkEn) begin
      if (wrHit(bsf_pkg::REG_TEMP_LIMITS))
        tempLimits_r <= merge(tempLimits_r, wData_r, wStrb_r);
      if (wrHit(bsf_pkg::REG_TEMP_HYS))
        tempHys_r <= merge(tempHys_r, wData_r, wStrb_r);
      if (wrHit(bsf_pkg::REG_CHARGE_PCT))
        chargePct_r <= merge(chargePct_r, wData_r, wStrb_r);
      if (wrHit(bsf_pkg::REG_SOC_WARN))
        socWarn_r <= merge(socWarn_r, wData_r, wStrb_r);
      if (wrHit(bsf_pkg::REG_CURRENT_CFG))
        currentCfg_r <= merge(currentCfg_r, wData_r, wStrb_r);
      if (wrHit(bsf_pkg::REG_INT_MASK) && wStrb_r[0])
        intMask_r <= wData_r[6:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [6:0] w1c;
  // No wrHit here: an assign only follows its operands, not a callee
  assign w1c = doWrite && awAddr_r == bsf_pkg::REG_INT_STATUS &&
               wStrb_r[0] ? wData_r[6:0] : 7'h00;

  // New events win over a simultaneous write-one-to-clear
  always_ff @(posedge clock) begin
    if (srst) begin
      intStatus_r <= '0;
    end else if (clkEn) begin
      intStatus_r <= (intStatus_r & ~w1c) | events;
    end
  end

  assign irq = |(intStatus_r & intMask_r);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    rdMux = 32'h0000_0000;
    rdMapped = 1'b1;
    case (s_axi_araddr)
      bsf_pkg::REG_FLAGS: rdMux = {26'h0, flags};
      bsf_pkg::REG_INT_STATUS: rdMux = {25'h0, intStatus_r};
      bsf_pkg::REG_INT_MASK: rdMux = {25'h0, intMask_r};
      bsf_pkg::REG_TEMP_LIMITS: rdMux = tempLimits_r;
      bsf_pkg::REG_TEMP_HYS: rdMux = tempHys_r;
      bsf_pkg::REG_CHARGE_PCT: rdMux = chargePct_r;
      bsf_pkg::REG_SOC_WARN: rdMux = socWarn_r;
      bsf_pkg::REG_CURRENT_CFG: rdMux = currentCfg_r;
      bsf_pkg::REG_STANDBY: rdMux = {16'h0, standby_current_value};
      bsf_pkg::REG_MAX_LOAD: rdMux = {16'h0, max_load_current_value};
      default: rdMapped = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= bsf_pkg::RESP_OKAY;
    end else if (clkEn) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdMapped ? bsf_pkg::RESP_OKAY
                                : bsf_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Field decode and comparisons
  // ----------------------------------------------------------------
  logic signed [17:0] tExt, overThr, underThr, hysE;
  logic signed [8:0] socS, alarmSet, alarmClr, fullSet, fullClr;
  logic [7:0] firstSet, firstClr, finalSet, finalClr, deadband;
  logic signed [15:0] initMaxLoad, eocDelta;
  logic signed [7:0] initStandby;
  logic alarmTermSel, fullTermSel;
  logic [5:0] setC, clrC, rises;

  assign tExt = 18'(temperature);
  assign overThr = 18'(signed'(tempLimits_r[bsf_pkg::LSB_H0 +: 16]));
  assign underThr = 18'(signed'(tempLimits_r[bsf_pkg::LSB_H1 +: 16]));
  assign hysE = {10'h000, tempHys_r[bsf_pkg::LSB_B0 +: 8]};
  assign eocDelta = tempHys_r[bsf_pkg::LSB_H1 +: 16];
  assign socS = {1'b0, chargePercent};
  assign alarmSet = 9'(signed'(chargePct_r[bsf_pkg::LSB_B0 +: 8]));
  assign alarmClr = 9'(signed'(chargePct_r[bsf_pkg::LSB_B1 +: 8]));
  assign fullSet = 9'(signed'(chargePct_r[bsf_pkg::LSB_B2 +: 8]));
  assign fullClr = 9'(signed'(chargePct_r[bsf_pkg::LSB_B3 +: 8]));
  assign alarmTermSel =
    chargePct_r[bsf_pkg::LSB_B0 +: 8] == bsf_pkg::PCT_TERM_SEL;
  assign fullTermSel =
    chargePct_r[bsf_pkg::LSB_B2 +: 8] == bsf_pkg::PCT_TERM_SEL;
  assign firstSet = socWarn_r[bsf_pkg::LSB_B0 +: 8];
  assign firstClr = socWarn_r[bsf_pkg::LSB_B1 +: 8];
  assign finalSet = socWarn_r[bsf_pkg::LSB_B2 +: 8];
  assign finalClr = socWarn_r[bsf_pkg::LSB_B3 +: 8];
  assign initStandby = currentCfg_r[bsf_pkg::LSB_B0 +: 8];
  assign deadband = currentCfg_r[bsf_pkg::LSB_B1 +: 8];
  assign initMaxLoad = currentCfg_r[bsf_pkg::LSB_H1 +: 16];

  assign setC[0] = tExt >= overThr;
  assign clrC[0] = tExt < overThr - hysE;
  assign setC[1] = tExt <= underThr;
  assign clrC[1] = tExt > underThr + hysE;
  assign setC[2] = alarmTermSel ? primaryTermination
                                : socS >= alarmSet;
  assign clrC[2] = socS < alarmClr;
  assign setC[3] = fullTermSel ? primaryTermination
                               : socS >= fullSet;
  assign clrC[3] = socS < fullClr;
  assign setC[4] = chargePercent <= firstSet;
  assign clrC[4] = chargePercent >= firstClr;
  assign setC[5] = chargePercent <= finalSet;
  assign clrC[5] = chargePercent >= finalClr;

  // Every flag is re-evaluated on each update tick
  for (genvar g = 0; g < 6; g++) begin : gFlag
    bsf_hyst_flag uFlag (
      .clock(clock),
      .srst(srst),
      .clkEn(clkEn),
      .tick(updateTick),
      .setCond(setC[g]),
      .clrCond(clrC[g]),
      .flag(flags[g]),
      .rise(rises[g])
    );
  end

  // ----------------------------------------------------------------
  // Gauging retrigger on temperature drift
  // ----------------------------------------------------------------
  logic signed [15:0] lastSimTemp_r;
  logic signed [16:0] tDiff, tAbs;
  logic simNow;

  assign tDiff = 17'(temperature) - 17'(lastSimTemp_r);
  assign tAbs = tDiff < 0 ? -tDiff : tDiff;
  assign simNow = clkEn && updateTick && tAbs >= 17'(eocDelta);
  assign events = {simNow, rises};

  always_ff @(posedge clock) begin
    if (srst) begin
      lastSimTemp_r <= '0;
      simUpdate <= 1'b0;
    end else if (clkEn) begin
      simUpdate <= simNow;
      if (simNow) begin
        lastSimTemp_r <= temperature;
      end
    end
  end

  // ----------------------------------------------------------------
  // Standby and max load reporting (signed, discharge negative)
  // ----------------------------------------------------------------
  logic secTick, standbyOk, belowHalf_r, avgNow, cfgWr;
  logic signed [16:0] iAbs, avgSum;

  bsf_period_tick #(.CYCLES(STANDBY_PERIOD_CYC)) uSec (
    .clock(clock),
    .srst(srst),
    .clkEn(clkEn),
    .pulse(secTick)
  );

  assign iAbs = current < 0 ? -17'(current) : 17'(current);
  assign standbyOk = iAbs > 17'({1'b0, deadband}) &&
                     17'(current) <= 17'(initStandby) * 17'sd2;
  assign avgNow = belowHalf_r && rises[3];
  assign avgSum = 17'(max_load_current_value) + 17'(initMaxLoad);
  assign cfgWr = doWrite && awAddr_r == bsf_pkg::REG_CURRENT_CFG;

  // A write to the current settings reloads the reported values from the settings held before that write
  always_ff @(posedge clock) begin
    if (srst) begin
      standby_current_value <=
        16'(signed'(bsf_pkg::CURRENT_CFG_RST[bsf_pkg::LSB_B0 +: 8]));
      max_load_current_value <= bsf_pkg::CURRENT_CFG_RST[bsf_pkg::LSB_H1 +: 16];
      belowHalf_r <= 1'b0;
    end else if (clkEn) begin
      if (cfgWr) begin
        standby_current_value <= 16'(initStandby);
      end else if (secTick && standbyOk) begin
        standby_current_value <= current;
      end
      if (cfgWr) begin
        max_load_current_value <= initMaxLoad;
      end else if (avgNow) begin
        max_load_current_value <= 16'(avgSum >>> 1);
      end else if (updateTick && current > initMaxLoad) begin
        max_load_current_value <= current;
      end
      if (avgNow) begin
        belowHalf_r <= 1'b0;
      end else if (updateTick && chargePercent < bsf_pkg::SOC_HALF) begin
        belowHalf_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_tick;
    clkEn && updateTick;
  endsequence

  property p_overSet;
    s_tick and (tExt >= overThr) |=> flags.overTemp;
  endproperty
  a_overSet: assert property (p_overSet)
    else $error("over-temperature not set");

  property p_underClr;
    s_tick and !(tExt <= underThr) and (tExt > underThr + hysE)
      |=> !flags.underTemp;
  endproperty
  a_underClr: assert property (p_underClr)
    else $error("under-temperature not cleared");

  property p_alarmPct;
    s_tick and !alarmTermSel and socS >= alarmSet |=> flags.chargeAlarm;
  endproperty
  a_alarmPct: assert property (p_alarmPct)
    else $error("charge alarm not set by level");

  property p_alarmTerm;
    s_tick and alarmTermSel and primaryTermination |=> flags.chargeAlarm;
  endproperty
  a_alarmTerm: assert property (p_alarmTerm)
    else $error("charge alarm not set by termination");

  property p_fullTerm;
    s_tick and fullTermSel and !primaryTermination and !flags.fullCharge
      |=> !flags.fullCharge;
  endproperty
  a_fullTerm: assert property (p_fullTerm)
    else $error("full charge set without termination");

  sequence s_simPulse;
    simUpdate ##1 !simUpdate || $past(simNow, 1);
  endsequence
  property p_simTrig;
    clkEn && simNow |=> s_simPulse;
  endproperty
  a_simTrig: assert property (p_simTrig)
    else $error("gauging retrigger missing");

  property p_standby;
    clkEn && secTick && standbyOk && !cfgWr
      |=> standby_current_value == $past(current);
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby current not updated");

  property p_maxLoad;
    s_tick and !avgNow and !cfgWr and current > initMaxLoad
      |=> max_load_current_value == $past(current);
  endproperty
  a_maxLoad: assert property (p_maxLoad)
    else $error("max load not replaced");

  property p_finalSoc;
    s_tick and chargePercent <= finalSet |=> flags.finalSoc;
  endproperty
  a_finalSoc: assert property (p_finalSoc)
    else $error("final warning not set");

  property p_firstSoc;
    s_tick and chargePercent > firstSet and chargePercent >= firstClr
      |=> !flags.firstSoc;
  endproperty
  a_firstSoc: assert property (p_firstSoc)
    else $error("first warning not cleared");
endmodule // bsf_flag_thresholds
`default_nettype wire

// ==== bsf_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Host master, one transfer at a time
// ----------------------------------------
module bsf_host_model (
  input wire logic clock,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready,
  output logic hung
);
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready, hung} = '0;
    wstrb = 4'hF;
  end

  // Ready is read before this edge's updates land
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
      output logic [1:0] r);
    int n;
    logic ta;
    logic tw;
    n = 0;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      ta |= awready;
      tw |= wready;
      awvalid <= !ta;
      wvalid <= !tw;
    end while (!(ta && tw) && ++n < 100);
    do @(posedge clock);
    while (!bvalid && ++n < 200);
    r = bresp;
    bready <= 1'b0;
    if (n >= 200) hung <= 1'b1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
      output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock);
    while (!arready && ++n < 100);
    arvalid <= 1'b0;
    do @(posedge clock);
    while (!rvalid && ++n < 200);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 200) hung <= 1'b1;
  endtask
endmodule // bsf_host_model
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic en = 1'b1;
  logic tick = 1'b0;
  logic term = 1'b0;
  logic signed [15:0] temp = 16'h00FA;
  logic signed [15:0] cur = 16'hFED4;
  logic [7:0] soc = 8'h32;
  logic [31:0] d;
  logic [1:0] r;
  int mismatches = 0;
  int comparisons = 0;
  int sims = 0;
  int s0;
  bsf_pkg::bsf_flags_t flags;
  logic signed [15:0] stby;
  logic signed [15:0] maxl;
  logic sim, irq, hung;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  // Temperature, flag bit, expected level
  localparam logic [23:0] TSEQ [8] = '{24'h022500, 24'h022601,
    24'h01F401, 24'h01F300, 24'h000110, 24'h000011, 24'h003211,
    24'h003310};
  // Charge, termination, flag bit, expected level
  localparam logic [19:0] SSEQ [16] = '{20'h63030, 20'h64031,
    20'h62031, 20'h61030, 20'h5F021, 20'h5E020, 20'h62020, 20'h63021,
    20'h0B040, 20'h0A041, 20'h0E041, 20'h0F040, 20'h03050, 20'h02051,
    20'h04051, 20'h05050};

  always #4 clock = ~clock;
  always @(posedge clock)
    if (sim) sims++;
  always @(posedge hung) begin
    mismatches++;
    summarize();
  end

  bsf_flag_thresholds #(.STANDBY_PERIOD_CYC(50)) bsf_flag_thresholds_inst (
    .clock(clock), .srst(srst), .clkEn(en), .updateTick(tick),
    .temperature(temp), .current(cur), .chargePercent(soc),
    .primaryTermination(term), .flags(flags), .standby_current_value(stby),
    .max_load_current_value(maxl), .simUpdate(sim), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  bsf_host_model host (.clock(clock), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .hung(hung));

  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    host.rd(a, d, r);
    chk("rdata", e, d);
  endtask

  // Inputs launch with the tick; the flag is read after its deciding edge
  task automatic tc(input logic [15:0] t, input logic [7:0] s,
      input logic m, input logic [3:0] i, input logic e);
    @(posedge clock);
    temp <= t;
    soc <= s;
    term <= m;
    tick <= 1'b1;
    @(posedge clock);
    tick <= 1'b0;
    @(posedge clock);
    #1;
    chk("flag", 32'(e), 32'(flags[i]));
  endtask

  task automatic summarize();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    chk("stby", 32'hFFFF_FFFD, 32'(stby));
    chk("maxl", 32'hFFFF_FF38, 32'(maxl));
    rdc(8'h0C, 32'h0000_0226);
    rdc(8'h10, 32'h0032_0032);
    rdc(8'h14, 32'h62FF_5F63);
    rdc(8'h18, 32'h0502_0F0A);
    rdc(8'h1C, 32'hFF38_05FD);
    rdc(8'h3C, 32'h0);
    chk("rresp", 32'h2, 32'(r));
    host.wr(8'h00, 32'h3F, r);
    chk("bresp", 32'h2, 32'(r));
    host.wr(8'h08, 32'h01, r);
    foreach (TSEQ[k])
      tc(TSEQ[k][23:8], 8'h32, 1'b0, TSEQ[k][7:4], TSEQ[k][0]);
    chk("irq", 32'h1, 32'(irq));
    rdc(8'h04, 32'h0000_0043);
    host.wr(8'h04, 32'h01, r);
    chk("irq", 32'h0, 32'(irq));
    host.wr(8'h08, 32'h40, r);
    chk("irq", 32'h1, 32'(irq));
    host.wr(8'h08, 32'h00, r);
    chk("irq", 32'h0, 32'(irq));
    tc(16'h00FA, 8'h32, 1'b0, 4'h0, 1'b0);
    s0 = sims;
    tc(16'h012B, 8'h32, 1'b0, 4'h0, 1'b0);
    chk("sims", 32'(s0), 32'(sims));
    tc(16'h012C, 8'h32, 1'b0, 4'h0, 1'b0);
    chk("sims", 32'(s0 + 1), 32'(sims));
    @(posedge clock) cur <= 16'hFF9C;
    tc(16'h012C, 8'h32, 1'b0, 4'h3, 1'b0);
    chk("maxl", 32'hFFFF_FF9C, 32'(maxl));
    @(posedge clock) cur <= 16'hFED4;
    tc(16'h012C, 8'h28, 1'b0, 4'h3, 1'b0);
    chk("maxl", 32'hFFFF_FF9C, 32'(maxl));
    tc(16'h012C, 8'h28, 1'b1, 4'h3, 1'b1);
    chk("maxl", 32'hFFFF_FF6A, 32'(maxl));
    host.wr(8'h14, 32'h62FF_5FFF, r);
    tc(16'h012C, 8'h32, 1'b1, 4'h2, 1'b1);
    tc(16'h012C, 8'h5E, 1'b0, 4'h3, 1'b0);
    chk("alarm", 32'h0, 32'(flags[2]));
    host.wr(8'h14, 32'h6264_5F63, r);
    foreach (SSEQ[k])
      tc(16'h012C, SSEQ[k][19:12], SSEQ[k][8], SSEQ[k][7:4], SSEQ[k][0]);
    // Three standby periods per case, so one missed tick still shows
    @(posedge clock) cur <= 16'hFFFC;
    repeat (150) @(posedge clock);
    chk("stby", 32'hFFFF_FED4, 32'(stby));
    @(posedge clock) cur <= 16'hFFFA;
    repeat (150) @(posedge clock);
    chk("stby", 32'hFFFF_FFFA, 32'(stby));
    @(posedge clock) cur <= 16'h000A;
    repeat (150) @(posedge clock);
    chk("stby", 32'hFFFF_FFFA, 32'(stby));
    // A tick while the clock enable is low must leave the over-temperature flag frozen
    @(posedge clock) en <= 1'b0;
    tc(16'h0226, 8'h32, 1'b0, 4'h0, 1'b0);
    @(posedge clock) en <= 1'b1;
    tc(16'h0226, 8'h32, 1'b0, 4'h0, 1'b1);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
